// [bench/ebwsg_mem_model.sv]
// external memory model answering the wait-state generator's bus
module ebwsg_mem_model (
  input  wire logic                     clk_i,
  input  wire ebwsg_pkg::ebwsg_bus_type bus_i,
  output logic [15:0]                   data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last;
  wire         rd_sel = !bus_i.ce_n && !bus_i.oe_n;
  // deselected bus shows the inverse of the last word so a stale value never passes
  assign data_o = rd_sel ? mem[bus_i.addr[3:0]] : ~last;
  initial last = 16'h0000;
  always @(posedge clk_i) begin
    if (!bus_i.ce_n && !bus_i.wr_n) mem[bus_i.addr[3:0]] <= bus_i.data;
    if (rd_sel) last <= data_o;
  end
endmodule : ebwsg_mem_model

// [bench/test_ext_bus_wait_state_gen.sv]
// self-checking bench for the external bus wait-state generator
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_ext_bus_wait_state_gen;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk_i, reset_n_i, wait_cfg_en_i, ext_mode_i, ctrl_we_i;
  logic [7:0]               ctrl_wdata_i, ctrl_rdata_o;
  ebwsg_pkg::ebwsg_req_type req_i;
  logic [15:0]              bus_data_i, rdata_o;
  logic                     busy_o, done_o;
  ebwsg_pkg::ebwsg_bus_type bus_o;
  int                       fails, checked, n;

  ebwsg_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .wait_cfg_en_i(wait_cfg_en_i),
    .ext_mode_i(ext_mode_i), .ctrl_we_i(ctrl_we_i), .ctrl_wdata_i(ctrl_wdata_i), .req_i(req_i),
    .bus_data_i(bus_data_i), .ctrl_rdata_o(ctrl_rdata_o), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o), .bus_o(bus_o));
  ebwsg_mem_model u_mem (.clk_i(clk_i), .bus_i(bus_o), .data_o(bus_data_i));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic ctrl_write(input logic [7:0] v);
    @(posedge clk_i);
    ctrl_we_i    <= 1'b1;
    ctrl_wdata_i <= v;
    @(posedge clk_i);
    ctrl_we_i <= 1'b0;
    #1;
  endtask : ctrl_write

  // returns edges from take to done; strobes, address and bus mode checked each clock until done
  task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                        output int cnt);
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, write: wr, addr: a, wdata: d};
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    cnt = 0;
    do begin
      @(posedge clk_i);
      #1;
      cnt++;
      if (done_o !== 1'b1) begin
        `CHK({busy_o, bus_o.bus_active, bus_o.ce_n, bus_o.oe_n, bus_o.wr_n}, {3'b110, wr, !wr})
        `CHK({bus_o.data_oe, bus_o.addr, bus_o.data}, {wr, a, d})
      end
    end while (done_o !== 1'b1 && cnt < 40);
    if (cnt >= 40) begin
      fails++;
      summarize();
    end
    `CHK({busy_o, bus_o.ce_n, bus_o.oe_n, bus_o.wr_n, bus_o.data_oe}, 5'b01110)
  endtask : access

  task automatic t_reset;
    `CHK(ctrl_rdata_o, 8'h30)
    access(1'b0, 20'h00001, 16'h0000, n);
    `CHK(n, 17)
  endtask : t_reset

  task automatic t_counts;
    for (int w = 0; w < 4; w++) begin
      ctrl_write({2'b00, w[1:0], 4'h0});
      `CHK(ctrl_rdata_o[5:4], w[1:0])
      access(1'b1, 20'h00005 + 20'(w), 16'ha5c0 + 16'(w), n);
      `CHK(n, 4 * (1 + w) + 1)
      access(1'b0, 20'h00005 + 20'(w), 16'h0000, n);
      `CHK(n, 4 * (1 + w) + 1)
      `CHK(rdata_o, 16'ha5c0 + 16'(w))
    end
  endtask : t_counts

  task automatic t_disabled;
    ctrl_write(8'h30);
    wait_cfg_en_i <= 1'b0;
    access(1'b0, 20'h00006, 16'h0000, n);
    `CHK(n, 5)
    wait_cfg_en_i <= 1'b1;
  endtask : t_disabled

  task automatic t_micro;
    ext_mode_i <= 1'b0;
    ctrl_write(8'h00);
    `CHK(ctrl_rdata_o, 8'h30)
    @(posedge clk_i);
    req_i <= '{valid: 1'b1, write: 1'b1, addr: 20'h00002, wdata: 16'h1234};
    @(posedge clk_i);
    req_i.valid <= 1'b0;
    repeat (20) begin
      @(posedge clk_i);
      #1;
      `CHK({done_o, busy_o, bus_o.bus_active, bus_o.ce_n}, 4'h1)
    end
    ext_mode_i <= 1'b1;
  endtask : t_micro

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    fails = 0;
    checked = 0;
    reset_n_i = 1'b0;
    wait_cfg_en_i = 1'b1;
    ext_mode_i = 1'b1;
    ctrl_we_i = 1'b0;
    ctrl_wdata_i = 8'h00;
    req_i = '0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    t_reset();
    t_counts();
    t_disabled();
    t_micro();
    summarize();
  end
endmodule : test_ext_bus_wait_state_gen

// [logic/ebwsg_pkg.sv]
// package: constants and carrier types for the external bus wait-state generator
package ebwsg_pkg;

  // wait-count field inside the memory bus control byte
  localparam int unsigned WAIT_FIELD_LSB   = 4;
  localparam int unsigned WAIT_FIELD_MSB   = 5;
  localparam logic [1:0]  WAIT_RESET       = 2'h3;
  localparam logic [7:0]  MEM_CTRL_RESET   = 8'h30;
  // one instruction cycle is four clock periods of the core clock
  localparam int unsigned CLK_PER_TCY      = 4;
  localparam logic [1:0]  TCY_LAST_PHASE   = 2'(CLK_PER_TCY - 1);

  typedef enum logic [1:0] {
    EBWSG_MODE_MCU  = 2'h0,
    EBWSG_MODE_EXT  = 2'h1
  } ebwsg_mode_type;

  // request from the core for one external table access
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [19:0] addr;
    logic [15:0] wdata;
  } ebwsg_req_type;

  // bus pins as driven by the device
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
    logic        data_oe;
    logic        ce_n;
    logic        oe_n;
    logic        wr_n;
    logic        bus_active;
  } ebwsg_bus_type;

endpackage : ebwsg_pkg

// [logic/ebwsg_tcy_timer.sv]
// instruction-cycle phase counter and wait-cycle down counter
module ebwsg_tcy_timer (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       load_i,
  input  wire logic [1:0] count_i,
  output logic            tcy_end_o,
  output logic            done_o
);

  logic [1:0] phase;
  logic [1:0] next_phase;
  logic [1:0] remain;
  logic [1:0] next_remain;

  always_comb begin
    next_phase  = phase + 2'h1;
    next_remain = remain;
    if (load_i) begin
      next_phase  = 2'h0;
      next_remain = count_i;
    end else if (phase == ebwsg_pkg::TCY_LAST_PHASE && remain != 2'h0) begin
      next_remain = remain - 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase  <= 2'h0;
      remain <= 2'h0;
    end else begin
      phase  <= next_phase;
      remain <= next_remain;
    end
  end

  assign tcy_end_o = (phase == ebwsg_pkg::TCY_LAST_PHASE);
  assign done_o    = (remain == 2'h0);

endmodule : ebwsg_tcy_timer

// [logic/ebwsg_top.sv]
// external bus wait-state generator: stretches table accesses by programmed cycles
module ebwsg_top (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic                     wait_cfg_en_i,
  input  wire logic                     ext_mode_i,
  input  wire logic                     ctrl_we_i,
  input  wire logic [7:0]               ctrl_wdata_i,
  input  wire ebwsg_pkg::ebwsg_req_type req_i,
  input  wire logic [15:0]              bus_data_i,
  output logic [7:0]                    ctrl_rdata_o,
  output logic                          busy_o,
  output logic                          done_o,
  output logic [15:0]                   rdata_o,
  output ebwsg_pkg::ebwsg_bus_type      bus_o
);

  typedef enum logic [1:0] {
    S_IDLE,
    S_ACCESS,
    S_WAIT,
    S_DONE
  } ebwsg_state_type;

  ebwsg_state_type          state;
  ebwsg_state_type          next_state;
  logic [7:0]               mem_ctrl;
  logic [7:0]               next_mem_ctrl;
  ebwsg_pkg::ebwsg_bus_type next_bus;
  logic                     next_busy;
  logic                     next_done;
  logic [15:0]              next_rdata;
  logic                     load;
  logic [1:0]               wait_count;
  logic                     tcy_end;
  logic                     wait_over;

  // wait count is zero unless the configuration bit enables waits
  assign wait_count = wait_cfg_en_i ?
                      mem_ctrl[ebwsg_pkg::WAIT_FIELD_MSB:ebwsg_pkg::WAIT_FIELD_LSB] :
                      2'h0;

  ebwsg_tcy_timer u_timer (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .load_i    (load),
    .count_i   (wait_count),
    .tcy_end_o (tcy_end),
    .done_o    (wait_over)
  );

  // control byte only writable in extended mode
  always_comb begin
    next_mem_ctrl = mem_ctrl;
    if (ctrl_we_i && ext_mode_i) begin
      next_mem_ctrl = ctrl_wdata_i;
    end
  end

  always_comb begin
    next_state = state;
    next_bus   = bus_o;
    next_busy  = busy_o;
    next_done  = 1'b0;
    next_rdata = rdata_o;
    load       = 1'b0;
    case (state)
      S_IDLE: begin
        next_bus.ce_n    = 1'b1;
        next_bus.oe_n    = 1'b1;
        next_bus.wr_n    = 1'b1;
        next_bus.data_oe = 1'b0;
        next_busy        = 1'b0;
        // no bus in microcontroller mode; requests are ignored
        next_bus.bus_active = ext_mode_i;
        if (req_i.valid && ext_mode_i) begin
          next_state       = S_ACCESS;
          load             = 1'b1;
          next_busy        = 1'b1;
          next_bus.addr    = req_i.addr;
          next_bus.data    = req_i.wdata;
          next_bus.data_oe = req_i.write;
          next_bus.ce_n    = 1'b0;
          next_bus.oe_n    = req_i.write;
          next_bus.wr_n    = !req_i.write;
        end
      end
      S_ACCESS: begin
        // the access itself takes one instruction cycle
        if (tcy_end) begin
          next_state = wait_over ? S_DONE : S_WAIT;
        end
      end
      S_WAIT: begin
        // bus outputs untouched here, so they hold for the whole wait
        if (tcy_end && wait_over) begin
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        next_rdata       = bus_data_i;
        next_done        = 1'b1;
        next_busy        = 1'b0;
        next_bus.ce_n    = 1'b1;
        next_bus.oe_n    = 1'b1;
        next_bus.wr_n    = 1'b1;
        next_bus.data_oe = 1'b0;
        next_state       = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= S_IDLE;
      mem_ctrl <= ebwsg_pkg::MEM_CTRL_RESET;
      bus_o    <= '{addr: 20'h0, data: 16'h0, data_oe: 1'b0, ce_n: 1'b1,
                    oe_n: 1'b1, wr_n: 1'b1, bus_active: 1'b0};
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      rdata_o  <= 16'h0;
      ctrl_rdata_o <= ebwsg_pkg::MEM_CTRL_RESET;
    end else begin
      state    <= next_state;
      mem_ctrl <= next_mem_ctrl;
      bus_o    <= next_bus;
      busy_o   <= next_busy;
      done_o   <= next_done;
      rdata_o  <= next_rdata;
      ctrl_rdata_o <= next_mem_ctrl;
    end
  end

  // helper: clocks from request acceptance to done
  logic [4:0] lat_cnt;
  logic [1:0] lat_wait;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lat_cnt  <= 5'h0;
      lat_wait <= 2'h0;
    end else if (state == S_IDLE && next_state == S_ACCESS) begin
      lat_cnt  <= 5'h0;
      lat_wait <= wait_count;
    end else if (lat_cnt != 5'h1f) begin
      lat_cnt  <= lat_cnt + 5'h1;
    end
  end

  sequence s_accept;
    state == S_IDLE && req_i.valid && ext_mode_i;
  endsequence

  // done is registered out of the done state, one clock after the last whole cycle
  a_done_latency: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_o |-> lat_cnt == 5'(ebwsg_pkg::CLK_PER_TCY * (1 + lat_wait) + 1))
    else $error("done not at programmed wait latency");

  a_no_wait_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (s_accept and !wait_cfg_en_i) |=> ##5 done_o)
    else $error("waits inserted while disabled");

  a_wait_field: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (s_accept and wait_cfg_en_i) |=>
      lat_wait == mem_ctrl[ebwsg_pkg::WAIT_FIELD_MSB:ebwsg_pkg::WAIT_FIELD_LSB])
    else $error("wait count not from control bits");

  a_reset_max: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |->
      mem_ctrl[ebwsg_pkg::WAIT_FIELD_MSB:ebwsg_pkg::WAIT_FIELD_LSB] == ebwsg_pkg::WAIT_RESET)
    else $error("wait field not three after reset");

  a_mcu_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == S_IDLE && !ext_mode_i) |=> bus_o.ce_n && !busy_o && !bus_o.bus_active)
    else $error("bus active in microcontroller mode");

  a_ext_active: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_accept |=> !bus_o.ce_n && bus_o.bus_active)
    else $error("bus not driven for external access");

  a_bus_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (state == S_WAIT) |-> $stable(bus_o.addr) && !bus_o.ce_n && busy_o)
    else $error("bus changed during wait");

  a_whole_tcy: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    done_o |-> lat_cnt[1:0] == 2'h1 && lat_cnt >= 5'h5)
    else $error("delay not whole instruction cycles");

endmodule : ebwsg_top
